// ==== src/dcdb_top.v ====
/*
 Driver chain datagram builder: APB register slave, configuration RAM,
 control signal snapshot and serial shifter toward a chain of up to
 three stepper drivers.
 Assumes pclk at 200 MHz, micro step signals on the same clock, and a
 driver chain that samples data on the rising edge of the serial clock.
*/
// Local design decisions: the register offsets and the APB register port.
// Behaviour
// - Every selectable control signal has its own five-bit code.
// - Codes 00000-00111: coil A current bits 0-5, polarity, fast decay.
// - Codes 01000-01111: coil B current bits 0-5, polarity, fast decay.
// - Code 10000 sends constant zero, code 10001 constant one.
// - Code 10010 sends direction: zero up/counter-clockwise, one down/clockwise.
// - Code 10011 sends the addressed motor's step bit.
// - Codes 10100-11111 are reserved and send one.
// - Three motors each offer the full selectable signal set.
// - Configuration uses the first 32 RAM words, 64 entries.
// - All control signals are snapshotted before sending; bits come from the snapshot.
// - A transmission starts at motor zero with the even entry of word zero.
// - Set flag below the last driver index advances to next motor.
// - Set flag at the last driver ends sending, counter back to zero.
// - Bit order follows RAM entry order; flags mark driver boundaries.
// - Without any set flag, sending never ends.
// - Datagrams go only on demand; reset values request none.
// - RAM reads and writes are accepted at any time, also while sending.
// - Reset loads register defaults (divider 3) and keeps motors at rest, not the RAM.
// - A register write can trigger a datagram from the current RAM.
// - RAM is chosen by a select bit; one more bit picks the range.
// - Each RAM word holds two entries: flag plus five-bit code.
`include "dcdb_defs.vh"

module dcdb_top (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	input wire [17:0] ms_dac_a,
	input wire [2:0] ms_coil_a_polarity,
	input wire [2:0] ms_coil_a_fast_decay,
	input wire [17:0] ms_dac_b,
	input wire [2:0] ms_coil_b_polarity,
	input wire [2:0] ms_coil_b_fast_decay,
	input wire [2:0] ms_direction,
	input wire [2:0] ms_step,
	input wire ms_send_req,
	output reg drv_sck,
	output reg drv_sdo,
	output reg drv_cs_n,
	output wire drv_busy
);

	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_LOW = 4'b0010;
	localparam [3:0] ST_HIGH = 4'b0100;
	localparam [3:0] ST_END = 4'b1000;
	localparam SNAP_W = `DCDB_MOTOR_W * `DCDB_MOTORS;

	// Configuration words; power-on content is whatever the cells hold
	reg [11:0] cfg_ram [0:`DCDB_RAM_WORDS-1];
	reg [1:0] last_driver_index_r;
	reg [7:0] half_div_r;
	reg [7:0] div_cnt_r;
	reg [3:0] state_r;
	reg [3:0] state_nxt;
	reg [1:0] motor_addr_r;
	reg [`DCDB_PTR_W-1:0] ptr_r;
	reg [SNAP_W-1:0] snap_r;
	reg pend_r;
	reg [5:0] entry;
	reg [`DCDB_MOTOR_W-1:0] motor_word;
	reg sel_bit;
	reg [1:0] last_wr;
	reg [31:0] ctrl_word;
	reg [31:0] stat_word;
	reg [31:0] rd_mux;
	wire [4:0] cfg_idx;
	wire [SNAP_W-1:0] live_sig;
	wire tick;
	wire apb_wr;
	wire apb_rd;
	wire [11:0] ofs;
	wire ram_hit;
	wire cfg_hit;
	wire reg_hit;
	wire sw_send;
	wire req_any;
	wire start;
	wire next_motor_flag;
	wire [4:0] code;

	// Parallel signals packed per motor so low codes index them directly
	genvar m;
	generate
		for (m = 0; m < `DCDB_MOTORS; m = m + 1)
		begin : g_pack
			assign live_sig[m*`DCDB_MOTOR_W +: `DCDB_MOTOR_W] = {ms_step[m], ms_direction[m],
				ms_coil_b_fast_decay[m], ms_coil_b_polarity[m], ms_dac_b[m*6 +: 6],
				ms_coil_a_fast_decay[m], ms_coil_a_polarity[m], ms_dac_a[m*6 +: 6]};
		end
	endgenerate

	// APB decode, zero wait states
	assign pready = 1'b1;
	assign apb_wr = psel & penable & pwrite;
	assign apb_rd = psel & penable & ~pwrite;
	assign ofs = {paddr[11:2], 2'b00};
	assign ram_hit = (ofs[11:9] == 3'h0) & ofs[`DCDB_RAM_SEL_BIT];
	assign cfg_hit = ram_hit & ~ofs[`DCDB_RANGE_BIT];
	assign cfg_idx = ofs[6:2];
	assign reg_hit = (ofs == `DCDB_CTRL_OFS) | (ofs == `DCDB_CMD_OFS) | (ofs == `DCDB_STAT_OFS);
	assign sw_send = apb_wr & (ofs == `DCDB_CMD_OFS) & pwdata[`DCDB_CMD_SEND_BIT];
	assign req_any = sw_send | ms_send_req | pend_r;
	assign start = (state_r == ST_IDLE) & req_any;
	assign drv_busy = ~state_r[0];

	// Last driver index clamped to the last existing motor,
	// so a frame never waits for a fourth driver that is not there
	always @*
	begin
		last_wr = pwdata[`DCDB_CTRL_LAST_LSB +: 2];
		if (pwdata[`DCDB_CTRL_LAST_LSB +: 2] > `DCDB_LAST_MAX)
			last_wr = `DCDB_LAST_MAX;
	end

	// Control registers, reset leaves no request pending
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			last_driver_index_r <= `DCDB_LAST_RST;
			half_div_r <= `DCDB_DIV_RST;
		end
		else if (apb_wr & (ofs == `DCDB_CTRL_OFS))
		begin
			last_driver_index_r <= last_wr;
			half_div_r <= pwdata[`DCDB_CTRL_DIV_LSB +: 8];
		end
	end

	// Configuration RAM write port, never reset
	always @(posedge pclk)
	begin
		if (apb_wr & cfg_hit)
		begin
			cfg_ram[cfg_idx] <= pwdata[11:0];
		end
	end

	// Register read mux; fields placed by their header positions
	always @*
	begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[`DCDB_CTRL_LAST_LSB +: 2] = last_driver_index_r;
		ctrl_word[`DCDB_CTRL_DIV_LSB +: 8] = half_div_r;
		stat_word = 32'h0000_0000;
		stat_word[`DCDB_STAT_BUSY_BIT] = drv_busy;
		stat_word[`DCDB_STAT_ADDR_LSB +: 2] = motor_addr_r;
		stat_word[`DCDB_STAT_PTR_LSB +: `DCDB_PTR_W] = ptr_r;
		stat_word[`DCDB_STAT_PEND_BIT] = pend_r;
		rd_mux = 32'h0000_0000;
		if (~pwrite)
		begin
			if (ofs == `DCDB_CTRL_OFS)
				rd_mux = ctrl_word;
			else if (ofs == `DCDB_STAT_OFS)
				rd_mux = stat_word;
		end
	end

	// Read data and error answer taken in the setup cycle,
	// so both already stand when the access edge samples them
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (psel & ~penable)
		begin
			pslverr <= ~(ram_hit | reg_hit);
			if (~pwrite & cfg_hit)
				prdata <= {20'h0_0000, cfg_ram[cfg_idx]};
			else
				prdata <= rd_mux;
		end
	end

	// Request held while a datagram is already in flight; set wins
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pend_r <= 1'b0;
		else if (~state_r[0] & (sw_send | ms_send_req))
			pend_r <= 1'b1;
		else if (start)
			pend_r <= 1'b0;
	end

	// Half bit period divider, one-cycle enable while sending
	assign tick = (div_cnt_r == 8'h00);
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_cnt_r <= 8'h00;
		else if (state_r[0] | tick)
			div_cnt_r <= half_div_r;
		else
			div_cnt_r <= div_cnt_r - 8'h01;
	end

	// Current entry: even half of a word first, then odd
	assign next_motor_flag = entry[`DCDB_FLAG_BIT];
	assign code = entry[4:0];
	always @*
	begin
		entry = ptr_r[0] ? cfg_ram[ptr_r[5:1]][11:6] : cfg_ram[ptr_r[5:1]][5:0];
		motor_word = snap_r[motor_addr_r*`DCDB_MOTOR_W +: `DCDB_MOTOR_W];
		if (!code[4])
			sel_bit = motor_word[code[3:0]];
		else
		begin
			case (code)
				`DCDB_CODE_ZERO: sel_bit = 1'b0;
				`DCDB_CODE_ONE: sel_bit = 1'b1;
				`DCDB_CODE_DIR: sel_bit = motor_word[`DCDB_DIR_POS];
				`DCDB_CODE_STEP: sel_bit = motor_word[`DCDB_STEP_POS];
				default: sel_bit = 1'b1;
			endcase
		end
	end

	// Bit sequencer
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
				if (req_any)
					state_nxt = ST_LOW;
			ST_LOW:
				if (tick)
					state_nxt = ST_HIGH;
			ST_HIGH:
				if (tick)
				begin
					// An index lowered mid-frame still ends the frame
					if (next_motor_flag & (motor_addr_r >= last_driver_index_r))
						state_nxt = ST_END;
					else
						state_nxt = ST_LOW;
				end
			ST_END:
				if (tick)
					state_nxt = ST_IDLE;
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	// Sequencer state
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Snapshot taken once per frame; later changes wait for the next one
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			snap_r <= {SNAP_W{1'b0}};
		else if (start)
			snap_r <= live_sig;
	end

	// Entry pointer, wrapping 63 to 0, and driver address counter
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			motor_addr_r <= 2'h0;
			ptr_r <= {`DCDB_PTR_W{1'b0}};
		end
		else if (start)
		begin
			motor_addr_r <= 2'h0;
			ptr_r <= {`DCDB_PTR_W{1'b0}};
		end
		else if ((state_r == ST_HIGH) & tick)
		begin
			ptr_r <= ptr_r + 6'h01;
			if (next_motor_flag)
			begin
				if (motor_addr_r < last_driver_index_r)
					motor_addr_r <= motor_addr_r + 2'h1;
				else
					motor_addr_r <= 2'h0;
			end
		end
	end

	// Frame select: low from the start edge to the end of the closing half period
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			drv_cs_n <= 1'b1;
		else if (start)
			drv_cs_n <= 1'b0;
		else if ((state_r == ST_END) & tick)
			drv_cs_n <= 1'b1;
	end

	// Serial data: parked low as a low phase opens, then the selected bit
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			drv_sdo <= 1'b0;
		else if (state_r == ST_LOW)
			drv_sdo <= sel_bit;
		else if (state_nxt == ST_LOW)
			drv_sdo <= 1'b0;
	end

	// Serial clock: rises after the low half period, falls after the high one
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			drv_sck <= 1'b0;
		else if ((state_r == ST_LOW) & tick)
			drv_sck <= 1'b1;
		else if ((state_r == ST_HIGH) & tick)
			drv_sck <= 1'b0;
	end

endmodule // dcdb_top

// ==== src/dcdb_defs.vh ====
/*
 Constants for the driver chain datagram builder: register offsets,
 field positions, reset values, selection codes and timing counts.
 Assumes inclusion by bare name from the design file.
*/
`ifndef DCDB_DEFS_VH
`define DCDB_DEFS_VH

// Register byte offsets on the APB side
`define DCDB_CTRL_OFS 12'h000
`define DCDB_CMD_OFS 12'h004
`define DCDB_STAT_OFS 12'h008
`define DCDB_RAM_BASE 12'h100
`define DCDB_RAM_SEL_BIT 8
`define DCDB_RANGE_BIT 7

// Control register fields
`define DCDB_CTRL_LAST_LSB 0
`define DCDB_CTRL_DIV_LSB 8
`define DCDB_LAST_RST 2'h0
`define DCDB_DIV_RST 8'h03
`define DCDB_LAST_MAX 2'h2

// Command register field
`define DCDB_CMD_SEND_BIT 0

// Status register fields
`define DCDB_STAT_BUSY_BIT 0
`define DCDB_STAT_ADDR_LSB 1
`define DCDB_STAT_PTR_LSB 3
`define DCDB_STAT_PEND_BIT 9

// Configuration entry layout
`define DCDB_ENTRY_W 6
`define DCDB_FLAG_BIT 5
`define DCDB_RAM_WORDS 32
`define DCDB_PTR_W 6

// Signal word per motor: selection codes 00000..01111 index it directly
`define DCDB_MOTOR_W 18
`define DCDB_MOTORS 3
`define DCDB_DIR_POS 16
`define DCDB_STEP_POS 17

// Selection codes in the upper half
`define DCDB_CODE_ZERO 5'h10
`define DCDB_CODE_ONE 5'h11
`define DCDB_CODE_DIR 5'h12
`define DCDB_CODE_STEP 5'h13

// Serial timing: smallest half bit period in ns at a 5 ns clock
`define DCDB_CLK_NS 5
`define DCDB_MIN_HALF_NS 5
`define DCDB_MIN_HALF_CYC ((`DCDB_MIN_HALF_NS + `DCDB_CLK_NS - 1) / `DCDB_CLK_NS)

`endif

// ==== tb/dcdb_props.sv ====
/* Checker for the dcdb_top ports: APB answers and serial framing.
 Assumes the bit divider stays at its reset value of 3. */
module dcdb_props (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pslverr,
	input wire ms_send_req,
	input wire drv_sck,
	input wire drv_sdo,
	input wire drv_cs_n,
	input wire drv_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Frame start, framing, bit timing and unmapped-address error
	a_idle_quiet: assert property (!drv_busy |-> drv_cs_n && !drv_sck) else $error("frame while idle");
	a_req_start: assert property (ms_send_req && !drv_busy |=> !drv_cs_n && drv_busy) else $error("no start");
	a_cmd_start: assert property (psel && penable && pwrite && paddr == 12'h004 && pwdata[0] && !drv_busy
		|=> drv_busy) else $error("no command start");
	a_sck_framed: assert property (drv_sck |-> !drv_cs_n) else $error("clock outside frame");
	a_sdo_hold: assert property (drv_sck |-> $stable(drv_sdo)) else $error("data moved");
	a_high_phase: assert property ($rose(drv_sck) |=> drv_sck [*3] ##1 !drv_sck) else $error("high phase");
	a_low_phase: assert property ($fell(drv_sck) |-> !drv_sck [*4]) else $error("low phase");
	a_err_unmapped: assert property (psel && !penable && paddr == 12'h00c |=> pslverr) else $error("no error");
endmodule // dcdb_props
bind dcdb_top dcdb_props u_props (.*);

// ==== tb/dcdb_chain_model.sv ====
/* Behavioural driver chain: takes one data bit at each serial clock rise.
 Assumes select active low and a clock that idles low. */
module dcdb_chain_model (
	input wire sck,
	input wire sdo,
	input wire cs_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic q[$];
	// Shift in while selected
	always @(posedge sck)
		if (!cs_n)
			q.push_back(sdo);
endmodule // dcdb_chain_model

// ==== tb/tb_top.sv ====
/* Bench for dcdb_top: APB master, random control signals, chain model.
 Assumes the checker is bound and the divider stays at 3. */
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ms_send_req = 0, err;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, lf = 32'd87424;
	logic [53:0] msv = 0, snap;
	logic pready, pslverr, drv_sck, drv_sdo, drv_cs_n, drv_busy;
	int fails = 0, num_checks = 0, cyc = 0;
	// Clock and instances
	always #2.5 pclk = ~pclk;
	dcdb_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.ms_dac_a(msv[17:0]), .ms_coil_a_polarity(msv[20:18]), .ms_coil_a_fast_decay(msv[23:21]),
		.ms_dac_b(msv[41:24]), .ms_coil_b_polarity(msv[44:42]), .ms_coil_b_fast_decay(msv[47:45]),
		.ms_direction(msv[50:48]), .ms_step(msv[53:51]), .ms_send_req, .drv_sck, .drv_sdo, .drv_cs_n, .drv_busy);
	dcdb_chain_model m_u (.sck(drv_sck), .sdo(drv_sdo), .cs_n(drv_cs_n));
	// Expectation helpers
	function automatic logic [31:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction
	function automatic logic fexp(logic [53:0] s, int m, logic [4:0] c);
		logic [17:0] w;
		w = {s[51+m], s[48+m], s[45+m], s[42+m], s[24+m*6+:6], s[21+m], s[18+m], s[m*6+:6]};
		if (c < 16)
			return w[c];
		return c == 16 ? 1'b0 : c == 18 ? w[16] : c == 19 ? w[17] : 1'b1;
	endfunction
	function automatic logic [5:0] ent(int e, int off, logic fl);
		return {fl && (e == 31 || e == 47 || e == 63), 5'((e + off) % 32)};
	endfunction
	// Bus cycle, result in rd and err
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic load(int off, logic fl);
		for (int w = 0; w < 32; w++)
			apb(1, 12'(12'h100 + w * 4), {20'h0, ent(2 * w + 1, off, fl), ent(2 * w, off, fl)});
	endtask
	task automatic frame(int off, logic viacmd);
		msv <= 54'({rnd(), rnd()});
		load(off, 1);
		snap = msv;
		m_u.q.delete();
		if (viacmd)
			apb(1, 12'h004, 32'h1);
		else
		begin
			@(posedge pclk) ms_send_req <= 1;
			@(posedge pclk) ms_send_req <= 0;
		end
		msv <= 54'({rnd(), rnd()});
		apb(0, 12'h100, 0);
		`CHK(rd[11:0], {ent(1, off, 1), ent(0, off, 1)})
		for (int k = 0; k < 3000 && drv_busy !== 1'b0; k++) @(posedge pclk);
		`CHK(drv_busy, 1'b0)
		`CHK(m_u.q.size(), 64)
		for (int e = 0; e < 64; e++)
			`CHK(m_u.q[e], fexp(snap, e < 32 ? 0 : e < 48 ? 1 : 2, 5'((e + off) % 32)))
		apb(0, 12'h008, 0);
		`CHK(rd[9:0], 10'h0)
	endtask
	task automatic end_of_test();
		if (fails == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Hang guard
	always @(posedge pclk)
		if (++cyc == 10000)
		begin
			fails++;
			end_of_test();
		end
	// Main sequence
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		repeat (20) @(posedge pclk);
		`CHK(drv_cs_n, 1'b1)
		apb(0, 12'h000, 0);
		`CHK(rd, 32'h300)
		apb(1, 12'h000, 32'h303);
		apb(0, 12'h000, 0);
		`CHK(rd, 32'h302)
		apb(0, 12'h00c, 0);
		`CHK(err, 1'b1)
		frame(0, 1);
		frame(16, 0);
		load(5, 0);
		apb(1, 12'h004, 32'h1);
		repeat (1500) @(posedge pclk);
		`CHK(drv_busy, 1'b1)
		apb(1, 12'h004, 32'h1);
		apb(0, 12'h008, 0);
		`CHK(rd[9], 1'b1)
		apb(1, 12'h17c, 32'h59c);
		apb(0, 12'h17c, 0);
		`CHK(rd[11:0], 12'h59c)
		apb(0, 12'h180, 0);
		`CHK({err, rd}, 33'h0)
		presetn <= 0;
		@(posedge pclk) presetn <= 1;
		apb(0, 12'h10c, 0);
		`CHK(rd[11:0], {ent(7, 5, 0), ent(6, 5, 0)})
		`CHK(drv_cs_n, 1'b1)
		apb(0, 12'h008, 0);
		`CHK(rd[9:0], 10'h0)
		end_of_test();
	end
endmodule // tb_top
